// File: dv/pebc_blank_ctrl_asserts.sv
// pebc_blank_ctrl_asserts: port-level checks of the edge blanking block.
// assumes one clk domain and event pins that stay put for several cycles.
`timescale 1ns/1ps
`default_nettype none
module pebc_blank_ctrl_asserts
    import pebc_pkg::*;
(
    // clock, reset and read channel
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    // blanking pins
    input wire logic        pwmRiseEdge,
    input wire logic        pwmFallEdge,
    input wire logic        extEventInput,
    input wire logic        syncedComparator1Out,
    input wire logic        syncedComparator2Out,
    input wire logic        syncedComparator3Out,
    input wire logic        extEventGated,
    input wire logic        cmp1Gated,
    input wire logic        cmp2Gated,
    input wire logic        cmp3Gated,
    input wire logic        riseBlankActive,
    input wire logic        fallBlankActive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [2:0] upCnt_ff;
    logic [1:0] blankHist_ff;
    logic [3:0] rdAddr_ff;
    logic       quiet;
    // history, so pass checks skip sync settling and window tails
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            upCnt_ff <= 3'h0;
            blankHist_ff <= 2'h0;
            rdAddr_ff <= 4'h0;
        end else begin
            upCnt_ff <= (upCnt_ff == 3'h7) ? upCnt_ff : upCnt_ff + 3'h1;
            blankHist_ff <= {blankHist_ff[0], riseBlankActive | fallBlankActive};
            if (s_axi_arvalid && s_axi_arready) rdAddr_ff <= s_axi_araddr;
        end
    end
    assign quiet = (upCnt_ff == 3'h7) && (blankHist_ff == 2'h0) && !riseBlankActive && !fallBlankActive;
    property p_rise_open; $rose(riseBlankActive) |-> $past(pwmRiseEdge); endproperty
    a_rise_open: assert property (p_rise_open) else $error("rise window opened without a rise edge");
    property p_fall_open; $rose(fallBlankActive) |-> $past(pwmFallEdge); endproperty
    a_fall_open: assert property (p_fall_open) else $error("fall window opened without a fall edge");
    property p_ext_pass; quiet && $past(extEventInput, 2) && $past(extEventInput, 3) |-> extEventGated; endproperty
    a_ext_pass: assert property (p_ext_pass) else $error("ext event dropped outside blanking");
    property p_cmp2_pass;
        quiet && $past(syncedComparator2Out, 2) && $past(syncedComparator2Out, 3) |-> cmp2Gated;
    endproperty
    a_cmp2_pass: assert property (p_cmp2_pass) else $error("cmp2 dropped outside blanking");
    property p_cmp1_low; !$past(syncedComparator1Out, 2) && !$past(syncedComparator1Out, 3) |-> !cmp1Gated; endproperty
    a_cmp1_low: assert property (p_cmp1_low) else $error("cmp1 event without source");
    property p_cmp3_low; !$past(syncedComparator3Out, 2) && !$past(syncedComparator3Out, 3) |-> !cmp3Gated; endproperty
    a_cmp3_low: assert property (p_cmp3_low) else $error("cmp3 event without source");
    property p_rd_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("read data above bit 7 not zero");
    property p_rd_mode; s_axi_rvalid && rdAddr_ff == PEBC_ADDR_MODE |-> (s_axi_rdata[7:0] & ~PEBC_MODE_MASK) == 8'h0;
    endproperty
    a_rd_mode: assert property (p_rd_mode) else $error("mode unused bits read nonzero");
    property p_rd_src; s_axi_rvalid && rdAddr_ff == PEBC_ADDR_RSRC |-> (s_axi_rdata[7:0] & ~PEBC_RSRC_MASK) == 8'h0;
    endproperty
    a_rd_src: assert property (p_rd_src) else $error("source unused bits read nonzero");
    c_rise: cover property (riseBlankActive);
    c_fall: cover property (fallBlankActive);
    c_read: cover property (s_axi_rvalid && rdAddr_ff == PEBC_ADDR_RSRC);
endmodule : pebc_blank_ctrl_asserts
bind pebc_blank_ctrl pebc_blank_ctrl_asserts pebc_blank_ctrl_asserts_inst (.clk, .nrst, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .pwmRiseEdge, .pwmFallEdge, .extEventInput, .syncedComparator1Out,
    .syncedComparator2Out, .syncedComparator3Out, .extEventGated, .cmp1Gated, .cmp2Gated, .cmp3Gated,
    .riseBlankActive, .fallBlankActive);
`default_nettype wire

// File: dv/test_pebc_blank_ctrl.sv
// test_pebc_blank_ctrl: directed bench for the edge blanking block.
// assumes the 0x0/0x4/0x8 map and a blanking time counted in clk cycles.
`timescale 1ns/1ps
`default_nettype none
module test_pebc_blank_ctrl;
    import pebc_pkg::*;
    localparam int BT = 3;
    logic        clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwmRiseEdge, pwmFallEdge;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, src;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    wire  [3:0]  gated;
    int          err_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    pebc_blank_ctrl pebc_blank_ctrl_inst (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwmRiseEdge,
        .pwmFallEdge, .extEventInput(src[3]), .syncedComparator3Out(src[2]), .syncedComparator2Out(src[1]),
        .syncedComparator1Out(src[0]), .extEventGated(gated[3]), .cmp3Gated(gated[2]), .cmp2Gated(gated[1]),
        .cmp1Gated(gated[0]), .riseBlankActive(), .fallBlankActive());
    task automatic results();
        if (err_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one bus access; each address or data item held until its own ready edge
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = w;
        @(posedge clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, 24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
        while (pa || pw) begin
            @(negedge clk);
            pa = pa && !(w ? s_axi_awready : s_axi_arready);
            pw = pw && !s_axi_wready;
            @(posedge clk);
            if (!pa) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
            if (!pw) s_axi_wvalid <= 1'b0;
        end
        do @(negedge clk); while (!(w ? s_axi_bvalid : s_axi_rvalid));
        q = s_axi_rdata;
        r = w ? s_axi_bresp : s_axi_rresp;
        @(posedge clk);
        {s_axi_bready, s_axi_rready} <= 2'b00;
    endtask : acc
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
        chk(32'(r), 32'(PEBC_RESP_OKAY));
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        acc(1'b0, a, 8'h0);
        chk(q, e);
        chk(32'(r), 32'(PEBC_RESP_OKAY));
    endtask : rd
    task automatic t_zeros();
        rd(PEBC_ADDR_MODE, 32'h0);
        rd(PEBC_ADDR_RSRC, 32'h0);
        rd(PEBC_ADDR_BTIM, 32'h0);
    endtask : t_zeros
    // unused bits dropped, every mode code stored in both fields, stray address refused
    task automatic t_fields();
        wr(PEBC_ADDR_MODE, 8'hff);
        rd(PEBC_ADDR_MODE, 32'h33);
        wr(PEBC_ADDR_RSRC, 8'hff);
        rd(PEBC_ADDR_RSRC, 32'h8e);
        for (int c = 0; c < 4; c++) begin
            wr(PEBC_ADDR_MODE, 8'((c << 4) | c));
            rd(PEBC_ADDR_MODE, 32'((c << 4) | c));
        end
        acc(1'b0, 4'h2, 8'h0);
        chk(32'(r), 32'(PEBC_RESP_SLVERR));
        acc(1'b1, 4'h2, 8'h0);
        chk(32'(r), 32'(PEBC_RESP_SLVERR));
    endtask : t_fields
    // pulse one pwm edge; window length checked per cycle, masked sources once in the third window cycle
    task automatic blank(input logic [7:0] mode, input logic [7:0] sel, input logic rise, input logic [3:0] g);
        logic act;
        act = rise ? (mode[1:0] == PEBC_BM_IMM) : (mode[5:4] == PEBC_BM_IMM);
        wr(PEBC_ADDR_RSRC, sel);
        wr(PEBC_ADDR_MODE, mode);
        @(posedge clk);
        {pwmRiseEdge, pwmFallEdge} <= {rise, !rise};
        @(posedge clk);
        {pwmRiseEdge, pwmFallEdge} <= 2'b00;
        for (int i = 0; i <= 4; i++) begin
            @(negedge clk);
            chk(32'(rise ? pebc_blank_ctrl_inst.riseBlankActive : pebc_blank_ctrl_inst.fallBlankActive),
                32'(act && i < BT));
            if (i == 2) chk(32'(gated), 32'(act ? g : 4'hf));
        end
        repeat (3) @(negedge clk);
        chk(32'(gated), 32'hf);
    endtask : blank
    task automatic t_blank();
        wr(PEBC_ADDR_BTIM, 8'(BT));
        blank(8'h01, 8'h8e, 1'b1, 4'h0);
        blank(8'h10, 8'h04, 1'b0, 4'hd);
        blank(8'h11, 8'h8a, 1'b1, 4'h2);
        blank(8'h11, 8'h02, 1'b0, 4'he);
        blank(8'h01, 8'h8e, 1'b0, 4'h0);
        blank(8'h22, 8'h8e, 1'b1, 4'h0);
        blank(8'h33, 8'h8e, 1'b0, 4'h0);
        // idle sources must never produce a gated event
        @(posedge clk);
        src <= 4'h0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(32'(gated), 32'h0);
        @(posedge clk);
        src <= 4'hf;
        repeat (4) @(posedge clk);
    endtask : t_blank
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard, well past the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            results();
        end
    end
    initial begin
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pwmRiseEdge, pwmFallEdge} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'h1;
        src = 4'hf;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_zeros();
        t_fields();
        t_blank();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_zeros();
        results();
    end
endmodule : test_pebc_blank_ctrl
`default_nettype wire

// File: rtl/pebc_blank_ctrl.sv
// pebc_blank_ctrl: edge blanking control of a switch-mode PWM controller.
// assumes AXI4-Lite software access, pwm edge pulses from the same clock, async event pins.
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module pebc_blank_ctrl
    import pebc_pkg::*;
#(
    parameter int BTIM_W = 8
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // axi4-lite write address
    input  wire logic [3:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    // axi4-lite write response
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [3:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // pwm edge pulses, same clock
    input  wire logic              pwmRiseEdge,
    input  wire logic              pwmFallEdge,
    // asynchronous event sources
    input  wire logic              extEventInput,
    input  wire logic              syncedComparator1Out,
    input  wire logic              syncedComparator2Out,
    input  wire logic              syncedComparator3Out,
    // gated event sources and blanking state
    output var  logic              extEventGated,
    output var  logic              cmp1Gated,
    output var  logic              cmp2Gated,
    output var  logic              cmp3Gated,
    output var  logic              riseBlankActive,
    output var  logic              fallBlankActive
);
    typedef struct packed {
        logic              awHeld;
        logic [3:0]        awAddr;
        logic              wHeld;
        logic [31:0]       wData;
        logic [3:0]        wStrb;
        logic              bValid;
        logic [1:0]        bResp;
        logic              rValid;
        logic [31:0]       rData;
        logic [1:0]        rResp;
        logic [7:0]        modeReg;
        logic [7:0]        rsrcReg;
        logic [BTIM_W-1:0] btimReg;
        logic [BTIM_W-1:0] riseCnt;
        logic [BTIM_W-1:0] fallCnt;
        logic              riseAct;
        logic              fallAct;
        logic [3:0]        gated;
    } pebc_state_t;

    pebc_state_t st_ff;
    pebc_state_t nxt_st;

    logic [3:0] srcSync;
    logic       doWrite;
    logic       blanking;
    logic [3:0] srcMask;
    pebc_bmode_t riseMode;
    pebc_bmode_t fallMode;

    // event pins from outside pass two flops before use
    for (genvar i = 0; i < 4; i++) begin : g_sync
        pebc_sync2 u_sync (
            .clk     (clk),
            .nrst    (nrst),
            .asyncIn ((i == 0) ? extEventInput : (i == 1) ? syncedComparator1Out :
                      (i == 2) ? syncedComparator2Out : syncedComparator3Out),
            .syncOut (srcSync[i])
        );
    end

    assign riseMode = pebc_bmode_t'(st_ff.modeReg[PEBC_RMODE_LSB +: 2]);
    assign fallMode = pebc_bmode_t'(st_ff.modeReg[PEBC_FMODE_LSB +: 2]);
    // one source mask serves both windows; no separate falling-source register here
    assign srcMask  = {st_ff.rsrcReg[PEBC_SRC_CMP3], st_ff.rsrcReg[PEBC_SRC_CMP2],
                       st_ff.rsrcReg[PEBC_SRC_CMP1], st_ff.rsrcReg[PEBC_SRC_EXT]};
    assign blanking = st_ff.riseAct | st_ff.fallAct;
    assign doWrite  = st_ff.awHeld & st_ff.wHeld & ~st_ff.bValid;

    // next state: bus slave, registers, blanking timers, gating
    always_comb begin
        nxt_st = st_ff;
        // capture address and data independently, either order
        if (s_axi_awvalid && !st_ff.awHeld) begin
            nxt_st.awHeld = 1'b1;
            nxt_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_ff.wHeld) begin
            nxt_st.wHeld = 1'b1;
            nxt_st.wData = s_axi_wdata;
            nxt_st.wStrb = s_axi_wstrb;
        end
        // commit once both halves are held; only the low lane carries data
        if (doWrite) begin
            nxt_st.awHeld = 1'b0;
            nxt_st.wHeld  = 1'b0;
            nxt_st.bValid = 1'b1;
            nxt_st.bResp  = PEBC_RESP_OKAY;
            if (st_ff.awAddr == PEBC_ADDR_MODE) begin
                if (st_ff.wStrb[0]) begin
                    nxt_st.modeReg = st_ff.wData[7:0] & PEBC_MODE_MASK;
                end
            end else if (st_ff.awAddr == PEBC_ADDR_RSRC) begin
                if (st_ff.wStrb[0]) begin
                    nxt_st.rsrcReg = st_ff.wData[7:0] & PEBC_RSRC_MASK;
                end
            end else if (st_ff.awAddr == PEBC_ADDR_BTIM) begin
                if (st_ff.wStrb[0]) begin
                    nxt_st.btimReg = st_ff.wData[BTIM_W-1:0];
                end
            end else if (st_ff.awAddr == PEBC_ADDR_STAT) begin
                nxt_st.bResp = PEBC_RESP_OKAY; // status is read-only, write ignored
            end else begin
                nxt_st.bResp = PEBC_RESP_SLVERR;
            end
        end
        if (st_ff.bValid && s_axi_bready) begin
            nxt_st.bValid = 1'b0;
        end
        // read: one cycle after address is taken
        if (s_axi_arvalid && !st_ff.rValid) begin
            nxt_st.rValid = 1'b1;
            nxt_st.rResp  = PEBC_RESP_OKAY;
            nxt_st.rData  = 32'h0000_0000;
            if (s_axi_araddr == PEBC_ADDR_MODE) begin
                nxt_st.rData[7:0] = st_ff.modeReg;
            end else if (s_axi_araddr == PEBC_ADDR_RSRC) begin
                nxt_st.rData[7:0] = st_ff.rsrcReg;
            end else if (s_axi_araddr == PEBC_ADDR_BTIM) begin
                nxt_st.rData[BTIM_W-1:0] = st_ff.btimReg;
            end else if (s_axi_araddr == PEBC_ADDR_STAT) begin
                nxt_st.rData[1:0] = {st_ff.fallAct, st_ff.riseAct};
            end else begin
                nxt_st.rResp = PEBC_RESP_SLVERR;
            end
        end else if (st_ff.rValid && s_axi_rready) begin
            nxt_st.rValid = 1'b0;
        end
        // rising window; reserved codes behave as no blanking
        if (pwmRiseEdge && riseMode == PEBC_BM_IMM && st_ff.btimReg != '0) begin
            nxt_st.riseAct = 1'b1;
            nxt_st.riseCnt = st_ff.btimReg;
        end else if (st_ff.riseAct) begin
            nxt_st.riseCnt = st_ff.riseCnt - 1'b1;
            nxt_st.riseAct = (st_ff.riseCnt != 1) && (riseMode == PEBC_BM_IMM);
        end
        // falling window; a zero time opens nothing
        if (pwmFallEdge && fallMode == PEBC_BM_IMM && st_ff.btimReg != '0) begin
            nxt_st.fallAct = 1'b1;
            nxt_st.fallCnt = st_ff.btimReg;
        end else if (st_ff.fallAct) begin
            nxt_st.fallCnt = st_ff.fallCnt - 1'b1;
            nxt_st.fallAct = (st_ff.fallCnt != 1) && (fallMode == PEBC_BM_IMM);
        end
        // suppress each selected source during the window
        nxt_st.gated[0] = srcSync[0] & ~(blanking & srcMask[0]);
        nxt_st.gated[1] = srcSync[1] & ~(blanking & srcMask[1]);
        nxt_st.gated[2] = srcSync[2] & ~(blanking & srcMask[2]);
        nxt_st.gated[3] = srcSync[3] & ~(blanking & srcMask[3]);
    end

    // every implemented bit clears on reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff         <= '0;
            st_ff.modeReg <= PEBC_MODE_RST;
            st_ff.rsrcReg <= PEBC_RSRC_RST;
            st_ff.btimReg <= PEBC_BTIM_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flops
    assign s_axi_awready   = ~st_ff.awHeld;
    assign s_axi_wready    = ~st_ff.wHeld;
    assign s_axi_bvalid    = st_ff.bValid;
    assign s_axi_bresp     = st_ff.bResp;
    assign s_axi_arready   = ~st_ff.rValid;
    assign s_axi_rvalid    = st_ff.rValid;
    assign s_axi_rdata     = st_ff.rData;
    assign s_axi_rresp     = st_ff.rResp;
    assign extEventGated   = st_ff.gated[0];
    assign cmp1Gated       = st_ff.gated[1];
    assign cmp2Gated       = st_ff.gated[2];
    assign cmp3Gated       = st_ff.gated[3];
    assign riseBlankActive = st_ff.riseAct;
    assign fallBlankActive = st_ff.fallAct;
endmodule : pebc_blank_ctrl
`default_nettype wire

// File: rtl/pebc_pkg.sv
// pebc_pkg: register map, field positions and mode codes of the edge blanking control block.
// assumes a 32-bit AXI4-Lite register bus and one 10 MHz clock.
package pebc_pkg;
    // register byte addresses
    localparam logic [3:0] PEBC_ADDR_MODE = 4'h0;
    localparam logic [3:0] PEBC_ADDR_RSRC = 4'h4;
    localparam logic [3:0] PEBC_ADDR_BTIM = 4'h8;
    localparam logic [3:0] PEBC_ADDR_STAT = 4'hc;
    // mode register fields
    localparam int PEBC_RMODE_LSB = 0;
    localparam int PEBC_FMODE_LSB = 4;
    localparam logic [7:0] PEBC_MODE_MASK = 8'h33;
    // rising blanked-source fields
    localparam int PEBC_SRC_CMP1 = 1;
    localparam int PEBC_SRC_CMP2 = 2;
    localparam int PEBC_SRC_CMP3 = 3;
    localparam int PEBC_SRC_EXT  = 7;
    localparam logic [7:0] PEBC_RSRC_MASK = 8'h8e;
    // reset values
    localparam logic [7:0] PEBC_MODE_RST = 8'h00;
    localparam logic [7:0] PEBC_RSRC_RST = 8'h00;
    localparam logic [7:0] PEBC_BTIM_RST = 8'h00;
    // AXI responses
    localparam logic [1:0] PEBC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PEBC_RESP_SLVERR = 2'h2;
    // blanking mode codes
    typedef enum logic [1:0] {
        PEBC_BM_NONE = 2'b00,
        PEBC_BM_IMM  = 2'b01,
        PEBC_BM_RSV2 = 2'b10,
        PEBC_BM_RSV3 = 2'b11
    } pebc_bmode_t;
endpackage : pebc_pkg

// File: rtl/pebc_sync2.sv
// pebc_sync2: two-flop synchroniser for one asynchronous level.
// assumes the input may change at any time relative to clk.
`timescale 1ns/1ps
`default_nettype none
module pebc_sync2 (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // level in and out
    input  wire logic asyncIn,
    output var  logic syncOut
);
    typedef struct packed {
        logic stage1;
        logic stage2;
    } pebc_sync_t;

    pebc_sync_t st_ff;
    pebc_sync_t nxt_st;

    // first stage feeds only the second
    always_comb begin
        nxt_st.stage1 = asyncIn;
        nxt_st.stage2 = st_ff.stage1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign syncOut = st_ff.stage2;
endmodule : pebc_sync2
`default_nettype wire
